// ---- dbc_channel.v ----
// Data break channel: four-port priority multiplexer, stolen-cycle sequencer and one block controller.
// Operation
// - Peripheral's 15-bit address goes straight into the memory address register.
// - Data moves between peripheral and memory buffer register, never the accumulator.
// - Data request outranks other interrupts; granted when current instruction ends.
// - Each grant stalls the program one memory cycle, or longer when a slow port stretches it, then it resumes.
// - Slow peripheral may stretch the cycle; processor honours it for the transfer.
// - One 18-bit word per 1.75 us cycle, 570,000 words per second peak.
// - Multiplexer gives four ports in fixed priority sharing the one channel.
// - Arithmetic registers stay unchanged during the stolen cycle.
// - Switch to port, assert ready to it, then start the transfer cycle.
// - Address sampled in slot one; data moves in slots two and three.
// - Select line to the serviced port marks the end of the cycle.
// - Block controller moves consecutive words to one of up to three devices.
// - Word counter loads block length complement and increments each word.
// - Location register holds next address and increments after each transfer.
// - Two 18-bit buffers exchange words with memory via memory buffer register.
// - Setup of address, direction and count comes from accumulator via distributor; here direction comes on i_io_dir_in.
// - Once set up, block runs by stealing cycles with no further instructions.
// - Block end signals program interrupt or automatic priority interrupt.
// - Block controllers may sit on multiplexer ports; here one sits on port 3.
`timescale 1ns/1ps
`include "dbc_consts.vh"
module dbc_channel #(
    parameter AW     = `DBC_ADDR_W,
    parameter DW     = `DBC_DATA_W,
    parameter NP     = `DBC_PORTS,
    parameter CYC_NS = `DBC_CYCLE_NS
) (
    input  wire            i_clock,
    input  wire            i_nrst,
    // Processor side.
    input  wire            i_instr_done,
    input  wire [DW-1:0]   i_mem_rdata,
    output reg             o_break_req_ff,
    output reg             o_prog_stall_ff,
    output reg             o_mem_wr_ff,
    output reg             o_mem_rd_ff,
    output reg  [AW-1:0]   o_mem_addr_reg_ff,
    output reg  [DW-1:0]   o_memory_buffer_reg_ff,
    // External ports 0..2; port 3 is taken by the block controller.
    input  wire [NP-2:0]   i_port_req,
    input  wire [NP-2:0]   i_port_dir_in,
    input  wire [NP-2:0]   i_port_slow,
    input  wire [(NP-1)*AW-1:0] i_port_addr,
    input  wire [(NP-1)*DW-1:0] i_port_wdata,
    output reg  [NP-1:0]   o_port_ready_ff,
    output reg  [NP-1:0]   o_port_select_ff,
    output reg  [DW-1:0]   o_port_rdata_ff,
    // Block controller setup through the information distributor.
    input  wire            i_io_load_addr,
    input  wire            i_io_load_count,
    input  wire            i_io_start,
    input  wire            i_io_dir_in,
    input  wire [1:0]      i_io_dev_sel,
    input  wire            i_io_use_api,
    input  wire [DW-1:0]   i_info_dist,
    // Block device side.
    input  wire            i_dev_valid,
    output wire            o_dev_ready,
    input  wire [DW-1:0]   i_dev_data,
    output reg             o_dev_valid_ff,
    input  wire            i_dev_ready,
    output reg  [DW-1:0]   o_dev_data_ff,
    output reg  [1:0]      o_dev_sel_ff,
    output reg             o_blk_busy_ff,
    output reg             o_blk_done_pi_ff,
    output reg             o_blk_done_api_ff
);
    // ------------------------------------------------------------
    // Cycle timing
    // ------------------------------------------------------------
    // Tick counts are whole clock periods; a clock that does not divide the cycle
    // evenly shortens the cycle slightly rather than stretching every transfer.
    localparam integer CYC = CYC_NS / `DBC_CLK_NS;
    localparam integer SLOT = CYC / `DBC_SLOTS;
    localparam integer CYC_M1_I = CYC - 1;
    localparam integer SLOT_3_I = 2 * SLOT;
    localparam [8:0] CYC_M1  = CYC_M1_I[8:0];
    localparam [8:0] SLOT_1  = SLOT[8:0];
    localparam [8:0] SLOT_3  = SLOT_3_I[8:0];
    // One-hot sequencer states.
    localparam [3:0] S_IDLE  = 4'h1;
    localparam [3:0] S_WAIT  = 4'h2;
    localparam [3:0] S_READY = 4'h4;
    localparam [3:0] S_CYC   = 4'h8;

    // ------------------------------------------------------------
    // Port gathering and fixed priority
    // ------------------------------------------------------------
    wire [NP-1:0]    req;
    wire [NP-1:0]    dir_in;
    wire [NP-1:0]    slow;
    wire [AW-1:0]    addr_v [0:NP-1];
    wire [DW-1:0]    wdat_v [0:NP-1];
    wire             blk_req;
    wire [DW-1:0]    blk_wdata;
    reg  [AW-1:0]    loc_ff;
    reg  [DW-1:0]    wc_ff;
    reg              bdir_in_ff;
    reg              use_api_ff;
    wire             ib_valid;
    wire [DW-1:0]    ib_data;
    wire             ib_pop;

    genvar g;
    generate
        for (g = 0; g < NP-1; g = g + 1) begin : g_port
            assign req[g]    = i_port_req[g];
            assign dir_in[g] = i_port_dir_in[g];
            assign slow[g]   = i_port_slow[g];
            assign addr_v[g] = i_port_addr[g*AW +: AW];
            assign wdat_v[g] = i_port_wdata[g*DW +: DW];
        end
    endgenerate
    assign req[NP-1]    = blk_req;
    assign dir_in[NP-1] = bdir_in_ff;
    assign slow[NP-1]   = 1'b0;
    assign addr_v[NP-1] = loc_ff;
    assign wdat_v[NP-1] = blk_wdata;

    // Lowest index wins; the rest keep their requests up and are seen next cycle.
    function [NP-1:0] pick;
        input [NP-1:0] r;
        integer k;
        begin
            pick = {NP{1'b0}};
            for (k = NP-1; k >= 0; k = k - 1) begin
                if (r[k]) begin
                    pick = {NP{1'b0}};
                    pick[k] = 1'b1;
                end
            end
        end
    endfunction

    // Binary index of the one-hot grant, used to steer the port multiplexers.
    function [1:0] enc;
        input [NP-1:0] oh;
        integer k;
        begin
            enc = 2'h0;
            for (k = 0; k < NP; k = k + 1) begin
                if (oh[k]) begin
                    enc = k[1:0];
                end
            end
        end
    endfunction

    // ------------------------------------------------------------
    // Stolen-cycle sequencer
    // ------------------------------------------------------------
    reg [3:0]    state_ff;
    reg [3:0]    nxt_state;
    reg [NP-1:0] gnt_ff;
    reg [8:0]    tick_ff;
    wire [1:0]   gi;
    wire         cyc_last;

    assign gi       = enc(gnt_ff);
    // A slow port holds the cycle at its last tick until it drops the stretch request.
    assign cyc_last = (tick_ff == CYC_M1) && !slow[gi];

    // The grant is latched in idle, so a port that raises its request later waits for the next cycle.
    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            S_IDLE:  if (|req) nxt_state = S_WAIT;
            S_WAIT:  if (i_instr_done) nxt_state = S_READY;
            S_READY: nxt_state = S_CYC;
            S_CYC:   if (cyc_last) nxt_state = S_IDLE;
            default: nxt_state = S_IDLE;
        endcase
    end

    assign ib_pop = (state_ff == S_CYC) && cyc_last && gnt_ff[NP-1] && !bdir_in_ff;

    // ------------------------------------------------------------
    // Memory cycle outputs
    // ------------------------------------------------------------
    always @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            state_ff               <= S_IDLE;
            gnt_ff                 <= {NP{1'b0}};
            tick_ff                <= 9'h000;
            o_break_req_ff         <= 1'b0;
            o_prog_stall_ff        <= 1'b0;
            o_mem_wr_ff            <= 1'b0;
            o_mem_rd_ff            <= 1'b0;
            o_mem_addr_reg_ff      <= `DBC_ZERO_ADDR;
            o_memory_buffer_reg_ff <= `DBC_ZERO_DATA;
            o_port_ready_ff        <= {NP{1'b0}};
            o_port_select_ff       <= {NP{1'b0}};
            o_port_rdata_ff        <= `DBC_ZERO_DATA;
        end else begin
            state_ff         <= nxt_state;
            o_port_select_ff <= {NP{1'b0}};
            o_mem_wr_ff      <= 1'b0;
            o_mem_rd_ff      <= 1'b0;
            // The break request follows the live requests in idle so it rises on the same edge that latches the grant.
            o_break_req_ff   <= (state_ff == S_IDLE) ? (|req) : (state_ff == S_WAIT);
            case (state_ff)
                S_IDLE: begin
                    gnt_ff <= pick(req);
                end
                S_WAIT: begin
                    if (i_instr_done) begin
                        o_prog_stall_ff <= 1'b1;
                    end
                end
                S_READY: begin
                    o_port_ready_ff <= gnt_ff;
                    tick_ff         <= 9'h000;
                end
                S_CYC: begin
                    // The counter parks on its last value while a slow port stretches the cycle.
                    if (!(tick_ff == CYC_M1)) begin
                        tick_ff <= tick_ff + 9'h001;
                    end
                    if (tick_ff == 9'h000) begin
                        o_mem_addr_reg_ff <= addr_v[gi];
                    end
                    if (tick_ff == SLOT_1) begin
                        if (dir_in[gi]) begin
                            o_memory_buffer_reg_ff <= wdat_v[gi];
                            o_mem_wr_ff            <= 1'b1;
                        end else begin
                            o_mem_rd_ff <= 1'b1;
                        end
                    end
                    if (tick_ff == SLOT_3 && !dir_in[gi]) begin
                        o_memory_buffer_reg_ff <= i_mem_rdata;
                        o_port_rdata_ff        <= i_mem_rdata;
                    end
                    if (cyc_last) begin
                        o_port_select_ff <= gnt_ff;
                        o_port_ready_ff  <= {NP{1'b0}};
                        o_prog_stall_ff  <= 1'b0;
                    end
                end
                default: begin
                    gnt_ff <= {NP{1'b0}};
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Block controller
    // ------------------------------------------------------------
    wire [DW-1:0] wc_inc;
    wire          blk_xfer;
    wire          in_ready;
    reg           out_push;

    // The counter holds the complement of the length, so the block ends where the step wraps to zero.
    assign wc_inc    = wc_ff + `DBC_ONE_DATA;
    assign blk_xfer  = (state_ff == S_CYC) && cyc_last && gnt_ff[NP-1];
    // Inbound words are only requested when buffered; outbound only when a buffer slot is free.
    assign blk_req   = o_blk_busy_ff && !gnt_ff[NP-1] &&
                       (bdir_in_ff ? ib_valid : !o_dev_valid_ff);
    assign blk_wdata = ib_data;

    // Inbound words wait here, so a device stall never holds a stolen cycle open.
    dbc_skid_buf #(
        .W (DW)
    ) u_in_buf (
        .i_clock (i_clock),
        .i_nrst  (i_nrst),
        .i_valid (i_dev_valid && o_blk_busy_ff && bdir_in_ff),
        .o_ready (in_ready),
        .i_data  (i_dev_data),
        .o_valid (ib_valid),
        .i_ready (ib_pop || (blk_xfer && bdir_in_ff)),
        .o_data  (ib_data)
    );

    assign o_dev_ready = in_ready && o_blk_busy_ff && bdir_in_ff;

    // Outbound words use a single register; the next word is requested only after the device
    // has taken this one, which costs throughput on slow devices but keeps the path simple.
    always @* begin
        out_push = blk_xfer && !bdir_in_ff;
    end

    // ------------------------------------------------------------
    // Block controller registers
    // ------------------------------------------------------------
    // A load during a running block wins over the step of the same cycle.
    always @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            loc_ff            <= `DBC_ZERO_ADDR;
            wc_ff             <= `DBC_ZERO_DATA;
            bdir_in_ff        <= 1'b0;
            use_api_ff        <= 1'b0;
            o_dev_sel_ff      <= 2'h0;
            o_blk_busy_ff     <= 1'b0;
            o_blk_done_pi_ff  <= 1'b0;
            o_blk_done_api_ff <= 1'b0;
            o_dev_valid_ff    <= 1'b0;
            o_dev_data_ff     <= `DBC_ZERO_DATA;
        end else begin
            if (i_io_load_addr) begin
                loc_ff <= i_info_dist[AW-1:0];
            end else if (blk_xfer) begin
                loc_ff <= loc_ff + `DBC_ONE_ADDR;
            end
            if (i_io_load_count) begin
                wc_ff <= i_info_dist;
            end else if (blk_xfer) begin
                wc_ff <= wc_inc;
            end
            if (i_io_start && !o_blk_busy_ff) begin
                bdir_in_ff    <= i_io_dir_in;
                use_api_ff    <= i_io_use_api;
                o_dev_sel_ff  <= i_io_dev_sel;
                o_blk_busy_ff <= 1'b1;
            end else if (blk_xfer && wc_inc == `DBC_ZERO_DATA) begin
                o_blk_busy_ff <= 1'b0;
            end
            // A new start clears completion, but a same-cycle end of block wins.
            if (blk_xfer && wc_inc == `DBC_ZERO_DATA) begin
                o_blk_done_pi_ff  <= !use_api_ff;
                o_blk_done_api_ff <= use_api_ff;
            end else if (i_io_start) begin
                o_blk_done_pi_ff  <= 1'b0;
                o_blk_done_api_ff <= 1'b0;
            end
            if (out_push) begin
                o_dev_valid_ff <= 1'b1;
                o_dev_data_ff  <= i_mem_rdata;
            end else if (i_dev_ready) begin
                o_dev_valid_ff <= 1'b0;
            end
        end
    end
endmodule

// ---- dbc_consts.vh ----
// Shared constants for the data break channel.
`ifndef DBC_CONSTS_VH
`define DBC_CONSTS_VH
`define DBC_ADDR_W        15
`define DBC_DATA_W        18
`define DBC_PORTS         4
`define DBC_BLK_DEVS      3
`define DBC_CYCLE_NS      1750
`define DBC_CLK_NS        10
`define DBC_SLOTS         3
`define DBC_ZERO_ADDR     15'h0000
`define DBC_ZERO_DATA     18'h00000
`define DBC_ONES_DATA     18'h3ffff
`define DBC_ONE_ADDR      15'h0001
`define DBC_ONE_DATA      18'h00001
`endif

// ---- dbc_skid_buf.v ----
// Two-entry valid/ready buffer in the data path.
`timescale 1ns/1ps
`include "dbc_consts.vh"
module dbc_skid_buf #(
    parameter W = `DBC_DATA_W
) (
    input  wire         i_clock,
    input  wire         i_nrst,
    input  wire         i_valid,
    output wire         o_ready,
    input  wire [W-1:0] i_data,
    output wire         o_valid,
    input  wire         i_ready,
    output wire [W-1:0] o_data
);
    reg [W-1:0] mem_ff [0:1];
    reg         wr_ff;
    reg         rd_ff;
    reg [1:0]   cnt_ff;
    wire        push;
    wire        pop;

    assign o_ready = (cnt_ff != 2'h2);
    assign o_valid = (cnt_ff != 2'h0);
    assign o_data  = mem_ff[rd_ff];
    assign push    = i_valid && o_ready;
    assign pop     = o_valid && i_ready;

    always @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            mem_ff[0] <= {W{1'b0}};
            mem_ff[1] <= {W{1'b0}};
            wr_ff     <= 1'b0;
            rd_ff     <= 1'b0;
            cnt_ff    <= 2'h0;
        end else begin
            if (push) begin
                mem_ff[wr_ff] <= i_data;
                wr_ff         <= ~wr_ff;
            end
            if (pop) begin
                rd_ff <= ~rd_ff;
            end
            if (push && !pop) begin
                cnt_ff <= cnt_ff + 2'h1;
            end else if (pop && !push) begin
                cnt_ff <= cnt_ff - 2'h1;
            end
        end
    end
endmodule

// ---- dbc_periph_model.sv ----
// Peripheral controller model for one multiplexer port.
`timescale 1ns/1ps
`include "dbc_consts.vh"
module dbc_periph_model (
    input  wire        i_clock,
    input  wire        i_go,
    input  wire        i_dir,
    input  wire        i_slow,
    input  wire [14:0] i_addr,
    input  wire [17:0] i_wdata,
    input  wire        i_select,
    input  wire        i_ready,
    output reg         o_req = 1'b0,
    output reg         o_dir_in = 1'b0,
    output reg         o_slow = 1'b0,
    output reg  [14:0] o_addr = 15'h0000,
    output reg  [17:0] o_wdata = 18'h00000
);
    reg [7:0] hold_cnt = 8'h00;

    // Released address, data and direction lines show the inverse of their last value, so a late sample cannot match by chance.
    always @(negedge i_clock) begin
        if (o_req && i_select) begin
            o_req <= 1'b0;
            o_slow <= 1'b0;
            o_addr <= ~o_addr;
            o_wdata <= ~o_wdata;
            o_dir_in <= ~o_dir_in;
            hold_cnt <= 8'h00;
        end else if (o_slow && i_ready) begin
            // Hold the stretch past the nominal cycle end, then let the cycle close.
            hold_cnt <= hold_cnt + 8'h01;
            if (hold_cnt == 8'hc8) begin
                o_slow <= 1'b0;
            end
        end else if (i_go && !o_req) begin
            o_req <= 1'b1;
            o_dir_in <= i_dir;
            o_slow <= i_slow;
            o_addr <= i_addr;
            o_wdata <= i_wdata;
        end
    end
endmodule

// ---- dbc_channel_properties.sv ----
// Concurrent checks on the data break channel ports.
`timescale 1ns/1ps
module dbc_channel_properties (
    input wire       i_clock,
    input wire       i_nrst,
    input wire       i_instr_done,
    input wire [2:0] i_port_dir_in,
    input wire [2:0] i_port_slow,
    input wire       o_prog_stall_ff,
    input wire       o_mem_wr_ff,
    input wire       o_mem_rd_ff,
    input wire [3:0] o_port_ready_ff,
    input wire [3:0] o_port_select_ff,
    input wire [1:0] o_dev_sel_ff,
    input wire       o_blk_busy_ff,
    input wire       o_blk_done_pi_ff,
    input wire       o_blk_done_api_ff
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_nrst);
    wire mem_access = o_mem_wr_ff || o_mem_rd_ff;
    a_ready_one_port:
        assert property ($onehot0(o_port_ready_ff)) else $error("two ports ready");
    a_select_after_ready:
        assert property ($rose(|o_port_select_ff) |-> $past(|o_port_ready_ff)) else $error("select without ready");
    a_slot_access:
        assert property ($rose(|o_port_ready_ff) |-> ##[56:60] mem_access) else $error("access slot off");
    a_cycle_end:
        assert property ($rose(|o_port_ready_ff) |-> ##[172:176]
            (|o_port_select_ff || |(o_port_ready_ff[2:0] & i_port_slow))) else $error("cycle length off");
    a_stall_after_done:
        assert property ($rose(o_prog_stall_ff) |-> $past(i_instr_done)) else $error("stall before instruction end");
    a_access_in_stall:
        assert property (mem_access |-> o_prog_stall_ff && |o_port_ready_ff) else $error("access outside stall");
    a_access_dir:
        assert property (mem_access && |o_port_ready_ff[2:0] |->
            o_mem_wr_ff == |(o_port_ready_ff[2:0] & i_port_dir_in)) else $error("direction wrong");
    a_done_one_kind:
        assert property (!(o_blk_done_pi_ff && o_blk_done_api_ff)) else $error("both done flags");
    a_done_not_busy:
        assert property (o_blk_done_pi_ff || o_blk_done_api_ff |-> !o_blk_busy_ff) else $error("done while busy");
    a_device_held:
        assert property (o_blk_busy_ff && $past(o_blk_busy_ff) |-> $stable(o_dev_sel_ff)) else $error("device moved");
    c_block_port: cover property ($rose(o_port_select_ff[3]));
    c_first_port: cover property ($rose(o_port_select_ff[0]));
    c_api_done: cover property ($rose(o_blk_done_api_ff));
endmodule
bind dbc_channel dbc_channel_properties u_props (.i_clock(i_clock), .i_nrst(i_nrst), .i_instr_done(i_instr_done),
    .i_port_dir_in(i_port_dir_in), .i_port_slow(i_port_slow), .o_prog_stall_ff(o_prog_stall_ff),
    .o_mem_wr_ff(o_mem_wr_ff),
    .o_mem_rd_ff(o_mem_rd_ff), .o_port_ready_ff(o_port_ready_ff), .o_port_select_ff(o_port_select_ff),
    .o_dev_sel_ff(o_dev_sel_ff), .o_blk_busy_ff(o_blk_busy_ff), .o_blk_done_pi_ff(o_blk_done_pi_ff),
    .o_blk_done_api_ff(o_blk_done_api_ff));

// ---- dbc_channel_bench.sv ----
// Self-checking bench for the data break channel.
`timescale 1ns/1ps
`include "dbc_consts.vh"
module dbc_channel_bench;
    typedef struct packed {logic [1:0] p; logic d; logic [14:0] a; logic [17:0] w;} dbc_xfer_t;
    reg         i_clock = 1'b0, i_nrst = 1'b0, i_instr_done = 1'b0;
    reg  [17:0] i_mem_rdata = 18'h00000, info = 18'h00000, dev_data = 18'h00000;
    reg  [2:0]  go = 3'h0, dir = 3'h0, slow = 3'h0;
    reg  [44:0] addr = 45'h0;
    reg  [53:0] wdata = 54'h0;
    reg         ld_addr = 1'b0, ld_count = 1'b0, start = 1'b0, io_dir = 1'b0, use_api = 1'b0;
    reg         dev_valid = 1'b0, dev_ready = 1'b0, rdy_rand = 1'b0;
    reg  [1:0]  dev_sel = 2'h0;
    reg  [3:0]  sel_prev = 4'h0;
    reg  [31:0] rnd, rr;
    wire [2:0]  port_req, port_dir, port_slow;
    wire [44:0] port_addr;
    wire [53:0] port_wdata;
    wire        o_break_req_ff, o_prog_stall_ff, o_mem_wr_ff, o_mem_rd_ff, o_dev_ready, o_dev_valid_ff;
    wire        o_blk_busy_ff, o_blk_done_pi_ff, o_blk_done_api_ff;
    wire [14:0] o_mem_addr_reg_ff;
    wire [17:0] o_memory_buffer_reg_ff, o_port_rdata_ff, o_dev_data_ff;
    wire [3:0]  o_port_ready_ff, o_port_select_ff;
    wire [1:0]  o_dev_sel_ff;
    integer     seed = 32'h8b45, errors = 0, check_count = 0, cycles = 0, refused, i;
    dbc_xfer_t  exp_q[$], e;
    reg  [17:0] out_q[$];
    genvar k;
    always #5 i_clock = ~i_clock;
    dbc_channel i_dbc_channel (.i_clock(i_clock), .i_nrst(i_nrst), .i_instr_done(i_instr_done),
        .i_mem_rdata(i_mem_rdata), .o_break_req_ff(o_break_req_ff), .o_prog_stall_ff(o_prog_stall_ff),
        .o_mem_wr_ff(o_mem_wr_ff), .o_mem_rd_ff(o_mem_rd_ff), .o_mem_addr_reg_ff(o_mem_addr_reg_ff),
        .o_memory_buffer_reg_ff(o_memory_buffer_reg_ff), .i_port_req(port_req), .i_port_dir_in(port_dir),
        .i_port_slow(port_slow), .i_port_addr(port_addr), .i_port_wdata(port_wdata),
        .o_port_ready_ff(o_port_ready_ff), .o_port_select_ff(o_port_select_ff), .o_port_rdata_ff(o_port_rdata_ff),
        .i_io_load_addr(ld_addr), .i_io_load_count(ld_count), .i_io_start(start), .i_io_dir_in(io_dir),
        .i_io_dev_sel(dev_sel), .i_io_use_api(use_api), .i_info_dist(info), .i_dev_valid(dev_valid),
        .o_dev_ready(o_dev_ready), .i_dev_data(dev_data), .o_dev_valid_ff(o_dev_valid_ff),
        .i_dev_ready(dev_ready), .o_dev_data_ff(o_dev_data_ff), .o_dev_sel_ff(o_dev_sel_ff),
        .o_blk_busy_ff(o_blk_busy_ff), .o_blk_done_pi_ff(o_blk_done_pi_ff), .o_blk_done_api_ff(o_blk_done_api_ff));
    generate
        for (k = 0; k < 3; k = k + 1) begin : g_port
            dbc_periph_model u_model (.i_clock(i_clock), .i_go(go[k]), .i_dir(dir[k]), .i_slow(slow[k]),
                .i_addr(addr[k*15+:15]), .i_wdata(wdata[k*18+:18]), .i_select(o_port_select_ff[k]),
                .i_ready(o_port_ready_ff[k]),
                .o_req(port_req[k]), .o_dir_in(port_dir[k]), .o_slow(port_slow[k]),
                .o_addr(port_addr[k*15+:15]), .o_wdata(port_wdata[k*18+:18]));
        end
    endgenerate
    function [17:0] mem_word(input [14:0] a);
        mem_word = {a[2:0], a} ^ 18'h2d4b1;
    endfunction
    task check(input ok, input [8*20-1:0] msg);
        begin
            check_count = check_count + 1;
            if (!ok) begin
                errors = errors + 1;
                $display("[FAIL] %0t %0s", $time, msg);
            end
        end
    endtask
    task conclude;
        begin
            if (errors == 0 && check_count > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask
    task port_set(input integer p, input d, input s);
        begin
            rnd = $random(seed);
            addr[p*15+:15] = rnd[14:0];
            wdata[p*18+:18] = rnd[31:14];
            dir[p] = d;
            slow[p] = s;
            exp_q.push_back({p[1:0], d, rnd[14:0], rnd[31:14]});
        end
    endtask
    task block(input [17:0] count, input [14:0] loc, input d, input [1:0] dev, input api);
        begin
            @(negedge i_clock) {info, ld_count} = {count, 1'b1};
            @(negedge i_clock) {ld_count, info, ld_addr} = {1'b0, 3'h0, loc, 1'b1};
            @(negedge i_clock) {ld_addr, io_dir, dev_sel, use_api, start} = {1'b0, d, dev, api, 1'b1};
            @(negedge i_clock) start = 1'b0;
        end
    endtask
    task drain;
        integer n;
        begin
            n = 0;
            while ((exp_q.size() != 0 || out_q.size() != 0 || o_blk_busy_ff !== 1'b0) && n < 3000) begin
                @(negedge i_clock);
                n = n + 1;
            end
            repeat (4) @(negedge i_clock);
            check(n < 3000 && o_prog_stall_ff === 1'b0 && o_break_req_ff === 1'b0, "transfer unfinished");
        end
    endtask
    // The core model answers every address with a word derived from it.
    always @(negedge i_clock) begin
        rr = $random(seed);
        i_instr_done <= rr[0];
        dev_ready <= rr[1] & rdy_rand;
        i_mem_rdata <= mem_word(o_mem_addr_reg_ff);
    end
    always @(posedge i_clock) begin
        sel_prev <= o_port_select_ff;
        if (|(o_port_select_ff & ~sel_prev)) begin
            check(exp_q.size() != 0, "unexpected transfer");
            if (exp_q.size() != 0) begin
                e = exp_q.pop_front();
                check(o_port_select_ff[e.p] === 1'b1, "port order");
                check(o_mem_addr_reg_ff === e.a, "address");
                if (e.d)
                    check(o_memory_buffer_reg_ff === e.w, "write data");
                else
                    check(o_memory_buffer_reg_ff === mem_word(e.a) &&
                        (e.p == 2'h3 || o_port_rdata_ff === mem_word(e.a)), "read data");
            end
        end
        if (o_dev_valid_ff === 1'b1 && dev_ready)
            check(out_q.size() != 0 && o_dev_data_ff === out_q.pop_front(), "device word");
    end
    always @(posedge i_clock) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            check(1'b0, "timeout");
            conclude;
        end
    end
    initial begin
        repeat (10) @(negedge i_clock);
        check(o_port_ready_ff === 4'h0 && o_dev_ready === 1'b0 && o_blk_busy_ff === 1'b0, "reset state");
        i_nrst = 1'b1;
        for (i = 0; i < 7; i = i + 1) begin
            @(negedge i_clock);
            if (i < 6) begin
                port_set(i / 2, i[0], i == 5);
                go <= 3'h1 << (i / 2);
            end else begin
                for (refused = 0; refused < 3; refused = refused + 1)
                    port_set(refused, refused[0], 1'b0);
                go <= 3'h7;
            end
            @(negedge i_clock) go <= 3'h0;
            drain;
        end
        block(18'h3fffc, 15'h7ffe, 1'b1, 2'h2, 1'b0);
        refused = 0;
        for (i = 0; i < 4; i = i + 1) begin
            rnd = $random(seed);
            exp_q.push_back({2'h3, 1'b1, 15'h7ffe + i[14:0], rnd[17:0]});
            {dev_valid, dev_data} = {1'b1, rnd[17:0]};
            while (o_dev_ready !== 1'b1 && refused < 5000) begin
                @(negedge i_clock);
                refused = refused + 1;
            end
            @(negedge i_clock);
        end
        dev_valid = 1'b0;
        check(refused > 0 && o_dev_sel_ff === 2'h2, "buffer or device");
        drain;
        check(o_blk_done_pi_ff === 1'b1 && o_blk_done_api_ff === 1'b0, "done to interrupt");
        rdy_rand = 1'b1;
        block(18'h3fffe, 15'h0100, 1'b0, 2'h1, 1'b1);
        for (i = 0; i < 2; i = i + 1) begin
            exp_q.push_back({2'h3, 1'b0, 15'h0100 + i[14:0], 18'h00000});
            out_q.push_back(mem_word(15'h0100 + i[14:0]));
        end
        drain;
        check(o_blk_done_api_ff === 1'b1 && o_blk_done_pi_ff === 1'b0, "done to priority");
        conclude;
    end
endmodule
